// ---- splw_defs.svh ----
// Register map, field positions, reset values and timing constants
`ifndef SPLW_DEFS_SVH
`define SPLW_DEFS_SVH
`define SPLW_OFF_TIMEOUT 16'h4171
`define SPLW_OFF_DURATION 16'h4176
`define SPLW_OFF_ENABLE 16'h4140
`define SPLW_OFF_STATUS 16'h4144
`define SPLW_TIMEOUT_RST 8'h05
`define SPLW_DURATION_RST 8'h05
`define SPLW_EN_GLOBAL_BIT 0
`define SPLW_EN_PORT4_BIT 5
`define SPLW_EN_PORT5_BIT 6
`define SPLW_TICK_NS 1000000
`define SPLW_CLK_NS 10
`define SPLW_TICK_CYC (`SPLW_TICK_NS / `SPLW_CLK_NS)
`define SPLW_OFF_BASE_MS 350
`define SPLW_OFF_STEP_MS 10
`define SPLW_LINK_BAD_LO 4'h4
`define SPLW_LINK_BAD_HI 4'h9
`endif

// ---- splw_pkg.sv ----
// Types shared by the split port watchdog
package splw_pkg;
  typedef enum logic [1:0] {
    SPLW_WATCH = 2'b00,
    SPLW_OFF = 2'b01,
    SPLW_IDLE = 2'b11
  } splw_state_type;
endpackage

// ---- splw_tick_if.sv ----
// Millisecond tick and settings handed to each port watcher
`timescale 1ns/1ps
interface splw_tick_if;
  logic msTick;
  logic [11:0] timeoutMs;
  logic [11:0] offMs;
  modport src (output msTick, output timeoutMs, output offMs);
  modport snk (input msTick, input timeoutMs, input offMs);
endinterface

// ---- splw_port.sv ----
// Watchdog for one split SuperSpeed port
`timescale 1ns/1ps
`include "splw_defs.svh"
module splw_port (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Settings
  splw_tick_if.snk tk,
  // Port
  input wire logic portEn,
  input wire logic [3:0] linkState,
  output logic powerOut,
  output logic pulseDone
);
  import splw_pkg::*;
  splw_state_type state_r;
  logic [11:0] msCnt_r;
  logic [3:0] lastState_r;
  logic stuck;
  assign stuck = linkState >= `SPLW_LINK_BAD_LO &&
    linkState <= `SPLW_LINK_BAD_HI && linkState == lastState_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= SPLW_WATCH;
      msCnt_r <= 12'h000;
      lastState_r <= 4'h0;
      powerOut <= 1'b1;
      pulseDone <= 1'b0;
    end else if (ce) begin
      lastState_r <= linkState;
      pulseDone <= 1'b0;
      case (state_r)
        SPLW_WATCH: begin
          if (!portEn || tk.timeoutMs == 12'h000 || !stuck) begin
            msCnt_r <= 12'h000;
          end else if (tk.msTick) begin
            if (msCnt_r + 12'h001 >= tk.timeoutMs) begin
              msCnt_r <= 12'h000;
              state_r <= SPLW_OFF;
              powerOut <= 1'b0;
            end else begin
              msCnt_r <= msCnt_r + 12'h001;
            end
          end
        end
        SPLW_OFF: begin
          if (tk.msTick) begin
            if (msCnt_r + 12'h001 >= tk.offMs) begin
              msCnt_r <= 12'h000;
              powerOut <= 1'b1;
              pulseDone <= 1'b1;
              state_r <= SPLW_WATCH;
            end else begin
              msCnt_r <= msCnt_r + 12'h001;
            end
          end
        end
        default: begin
          state_r <= SPLW_WATCH;
          powerOut <= 1'b1;
        end
      endcase
    end
  end
  // output stays low for the whole pulse
  a_off_low: assert property (@(posedge clk) disable iff (rst)
    state_r == SPLW_OFF |-> !powerOut) else $error("power high in pulse");
  a_cnt_bound: assert property (@(posedge clk) disable iff (rst)
    state_r == SPLW_WATCH && tk.timeoutMs != 12'h000 |->
    msCnt_r < tk.timeoutMs) else $error("timeout count overran");
  a_done_high: assert property (@(posedge clk) disable iff (rst)
    pulseDone |-> powerOut) else $error("pulse end with power low");
endmodule // splw_port

// ---- splw_top.sv ----
// Split port link watchdog with AXI4-Lite registers
//
// Operation
// - Pulse a split port power output after the link stays invalid too long.
// - Clear and restart the link timer on every timeout.
// - Timeout code 0 disables; 1-6 select 100ms to 2s; 7 reserved.
// - One timeout setting shared by all split ports.
// - Hold power off for the duration from the toggle-time field.
// - Toggle-time zero means 350 ms off.
// - Each toggle-time unit adds 10 ms to the 350 ms base.
// - Clear the off timer when a pulse finishes.
// - Off duration only applies to watchdog pulses on split outputs.
// - Link invalid if stuck in one state 0x4..0x9 for the timeout.
// - Drive output low during pulse, high again afterwards.
// - Only ports 4 and 5 split; needs port bit and global bit.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "splw_defs.svh"
module splw_top #(
  parameter int TICK_CYC = `SPLW_TICK_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // AXI4-Lite write
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Link state of ports 4 and 5
  input wire logic [3:0] linkStateStatus4,
  input wire logic [3:0] linkStateStatus5,
  // Split power outputs
  output logic splitSuperspeedPowerOut4,
  output logic splitSuperspeedPowerOut5
);
  import splw_pkg::*;
  logic [7:0] timeoutSel_r;
  logic [7:0] offDur_r;
  logic [7:0] enable_r;
  logic [1:0] pulseSeen_r;
  logic [31:0] tickCnt_r;
  logic [15:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic awHave_r;
  logic wHave_r;
  logic [11:0] timeoutMs_nxt;
  logic [1:0] powerOut;
  logic [1:0] pulseDone;
  logic [1:0] portEn;
  logic doWrite;
  splw_tick_if tk ();

  always_comb begin
    case (timeoutSel_r[2:0])
      3'h1: timeoutMs_nxt = 12'd100;
      3'h2: timeoutMs_nxt = 12'd250;
      3'h3: timeoutMs_nxt = 12'd500;
      3'h4: timeoutMs_nxt = 12'd750;
      3'h5: timeoutMs_nxt = 12'd1000;
      3'h6: timeoutMs_nxt = 12'd2000;
      default: timeoutMs_nxt = 12'd0;
    endcase
  end
  assign tk.timeoutMs = timeoutMs_nxt;
  assign tk.offMs = 12'(`SPLW_OFF_BASE_MS) +
    12'(offDur_r) * 12'(`SPLW_OFF_STEP_MS);

  // Millisecond tick
  always_ff @(posedge clk) begin
    if (rst) begin
      tickCnt_r <= 32'h0;
      tk.msTick <= 1'b0;
    end else if (ce) begin
      tk.msTick <= 1'b0;
      if (tickCnt_r >= 32'(TICK_CYC - 1)) begin
        tickCnt_r <= 32'h0;
        tk.msTick <= 1'b1;
      end else begin
        tickCnt_r <= tickCnt_r + 32'h1;
      end
    end
  end

  assign portEn[0] = enable_r[`SPLW_EN_PORT4_BIT] &
    enable_r[`SPLW_EN_GLOBAL_BIT];
  assign portEn[1] = enable_r[`SPLW_EN_PORT5_BIT] &
    enable_r[`SPLW_EN_GLOBAL_BIT];

  splw_port u_port4 (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .tk(tk),
    .portEn(portEn[0]),
    .linkState(linkStateStatus4),
    .powerOut(powerOut[0]),
    .pulseDone(pulseDone[0])
  );
  splw_port u_port5 (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .tk(tk),
    .portEn(portEn[1]),
    .linkState(linkStateStatus5),
    .powerOut(powerOut[1]),
    .pulseDone(pulseDone[1])
  );

  // Output flops
  always_ff @(posedge clk) begin
    if (rst) begin
      splitSuperspeedPowerOut4 <= 1'b1;
      splitSuperspeedPowerOut5 <= 1'b1;
    end else if (ce) begin
      splitSuperspeedPowerOut4 <= powerOut[0];
      splitSuperspeedPowerOut5 <= powerOut[1];
    end
  end

  // Write channel capture
  assign doWrite = awHave_r && wHave_r && !s_axi_bvalid;
  always_ff @(posedge clk) begin
    if (rst) begin
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      awAddr_r <= 16'h0;
      wData_r <= 32'h0;
      wStrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (ce) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (s_axi_awvalid && !awHave_r && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
        awHave_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHave_r && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
        wHave_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHave_r <= 1'b0;
        wHave_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr_r == 16'(`SPLW_OFF_TIMEOUT * 4) ||
          awAddr_r == 16'(`SPLW_OFF_DURATION * 4) ||
          awAddr_r == 16'(`SPLW_OFF_ENABLE * 4) ||
          awAddr_r == 16'(`SPLW_OFF_STATUS * 4)) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register file writes
  always_ff @(posedge clk) begin
    if (rst) begin
      timeoutSel_r <= `SPLW_TIMEOUT_RST;
      offDur_r <= `SPLW_DURATION_RST;
      enable_r <= 8'h00;
    end else if (ce && doWrite && wStrb_r[0]) begin
      if (awAddr_r == 16'(`SPLW_OFF_TIMEOUT * 4)) begin
        timeoutSel_r <= {5'h00, wData_r[2:0]};
      end
      if (awAddr_r == 16'(`SPLW_OFF_DURATION * 4)) begin
        offDur_r <= wData_r[7:0];
      end
      if (awAddr_r == 16'(`SPLW_OFF_ENABLE * 4)) begin
        enable_r <= wData_r[7:0] & 8'h61;
      end
    end
  end

  // Sticky pulse-done status, set wins over write-one-to-clear
  always_ff @(posedge clk) begin
    if (rst) begin
      pulseSeen_r <= 2'b00;
    end else if (ce) begin
      if (doWrite && wStrb_r[0] &&
          awAddr_r == 16'(`SPLW_OFF_STATUS * 4)) begin
        pulseSeen_r <= (pulseSeen_r & ~wData_r[1:0]) | pulseDone;
      end else begin
        pulseSeen_r <= pulseSeen_r | pulseDone;
      end
    end
  end

  // Read channel
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
    end else if (ce) begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else if (s_axi_arvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          16'(`SPLW_OFF_TIMEOUT * 4):
            s_axi_rdata <= {24'h0, timeoutSel_r};
          16'(`SPLW_OFF_DURATION * 4):
            s_axi_rdata <= {24'h0, offDur_r};
          16'(`SPLW_OFF_ENABLE * 4):
            s_axi_rdata <= {24'h0, enable_r};
          16'(`SPLW_OFF_STATUS * 4):
            s_axi_rdata <= {28'h0, powerOut, pulseSeen_r};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
    end
  end

  a_unsplit_on: assert property (@(posedge clk) disable iff (rst)
    !portEn[0] && $past(!portEn[0]) && $past(!portEn[0], 2) &&
    $past(powerOut[0]) |-> splitSuperspeedPowerOut4)
    else $error("unsplit port toggled");
  a_zero_none: assert property (@(posedge clk) disable iff (rst)
    timeoutSel_r[2:0] == 3'h0 && $past(timeoutSel_r[2:0] == 3'h0) &&
    $past(powerOut[1]) |-> powerOut[1]) else $error("toggle while off");
  a_ce_freeze: assert property (@(posedge clk) disable iff (rst)
    !ce |=> $stable(splitSuperspeedPowerOut4))
    else $error("output moved while frozen");
endmodule // splw_top

// ---- splw_switch_model.sv ----
// Model of the embedded device behind a split power switch
`timescale 1ns/1ps
module splw_switch_model #(
  parameter logic [3:0] STUCK_CODE = 4'h5,
  parameter int TRAIN_CYC = 20
) (
  // Clock
  input wire logic clk,
  // Switch and fault control
  input wire logic powerOn,
  input wire logic stuck,
  // Link state seen by the hub
  output logic [3:0] linkState = 4'h5
);
  int train = 0;
  // Unpowered sits in detect; a faulty device never moves on
  always @(posedge clk) begin
    if (!powerOn || stuck) begin
      train <= 0;
      linkState <= stuck ? STUCK_CODE : 4'h5;
    end else if (train < TRAIN_CYC) begin
      train <= train + 1;
      linkState <= train[0] ? 4'h7 : 4'h8;
    end else begin
      linkState <= 4'h0;
    end
  end
endmodule // splw_switch_model

// ---- test_split_port_link_watchdog.sv ----
// Self-checking bench for the split port link watchdog
`timescale 1ns/1ps
`include "splw_defs.svh"
module test_split_port_link_watchdog;
  localparam int T = 5;
  localparam int TOL = 2 * T + 4;
  localparam logic [15:0] aTo = 16'(`SPLW_OFF_TIMEOUT << 2);
  localparam logic [15:0] aDur = 16'(`SPLW_OFF_DURATION << 2);
  localparam logic [15:0] aEn = 16'(`SPLW_OFF_ENABLE << 2);
  localparam logic [15:0] aSt = 16'(`SPLW_OFF_STATUS << 2);
  logic clk = '0, rst = '1;
  logic awValid = '0, wValid = '0, bReady = '0, arValid = '0, rReady = '0;
  logic [15:0] awAddr = '0, arAddr = '0;
  logic [31:0] wData = '0, rData;
  logic [1:0] bResp, rResp;
  logic awReady, wReady, bValid, arReady, rValid, pwr4, pwr5;
  logic stuck4 = '0, stuck5 = '0;
  logic [3:0] link4, link5;
  int n_mismatch = 0, checked = 0;
  int ms [6] = '{100, 250, 500, 750, 1000, 2000};
  always #5 clk = ~clk;
  splw_top #(.TICK_CYC(T)) uut (.clk(clk), .rst(rst), .ce(1'h1),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .linkStateStatus4(link4),
    .linkStateStatus5(link5), .splitSuperspeedPowerOut4(pwr4),
    .splitSuperspeedPowerOut5(pwr5));
  splw_switch_model #(.STUCK_CODE(4'h4)) dev4 (.clk(clk),
    .powerOn(pwr4), .stuck(stuck4), .linkState(link4));
  splw_switch_model #(.STUCK_CODE(4'h9)) dev5 (.clk(clk),
    .powerOn(pwr5), .stuck(stuck5), .linkState(link5));
  task automatic close_out;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic hang;
    n_mismatch++;
    $display("MISMATCH wait expected response seen none");
    close_out();
  endtask
  task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic inRange(input string nm, input int n, input int e);
    if (n > e - TOL && n < e + TOL) checked++;
    else chk(nm, n, e);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
      input logic [1:0] er);
    int n;
    n = 0;
    awAddr <= a;
    wData <= {24'h0, d};
    awValid <= '1;
    wValid <= '1;
    bReady <= '1;
    do begin
      @(posedge clk);
      n++;
      if (awReady) awValid <= '0;
      if (wReady) wValid <= '0;
    end while (bValid !== 1'h1 && n < 100);
    bReady <= '0;
    if (n >= 100) hang();
    chk("bresp", bResp, er);
    @(posedge clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] ed,
      input logic [1:0] er);
    int n;
    n = 0;
    arAddr <= a;
    arValid <= '1;
    rReady <= '1;
    do begin
      @(posedge clk);
      n++;
      if (arReady) arValid <= '0;
    end while (rValid !== 1'h1 && n < 100);
    rReady <= '0;
    if (n >= 100) hang();
    chk("rdata", rData, {24'h0, ed});
    chk("rresp", rResp, er);
    @(posedge clk);
  endtask
  task automatic waitPwr(input logic lvl, input int mx, input logic must,
      output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pwr4 !== lvl && n < mx);
    if (must && n >= mx) hang();
  endtask
  task automatic pulse(input int tms, input int off);
    int c;
    waitPwr('0, tms * T + 100, '1, c);
    inRange("fall", c, tms * T);
    chk("pwr5", pwr5, 1'h0);
    waitPwr('1, off * T + 100, '1, c);
    inRange("low", c, off * T);
  endtask
  task automatic quiet;
    int c;
    waitPwr('0, 2500, '0, c);
    chk("quiet4", pwr4, 1'h1);
    chk("quiet5", pwr5, 1'h1);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= '0;
    @(posedge clk);
    rd(aTo, `SPLW_TIMEOUT_RST, 2'h0);
    rd(aDur, `SPLW_DURATION_RST, 2'h0);
    rd(16'h0004, 8'h00, 2'h2);
    wr(16'h0004, 8'h33, 2'h2);
    wr(aEn, 8'hff, 2'h0);
    rd(aEn, 8'h61, 2'h0);
    for (int i = 0; i < 6; i++) begin
      wr(aTo, 8'(i + 1), 2'h0);
      wr(aDur, 8'(i), 2'h0);
      rd(aDur, 8'(i), 2'h0);
      stuck4 <= '1;
      stuck5 <= '1;
      pulse(ms[i], 350 + 10 * i);
      if (i == 0) pulse(100, 350);
      stuck4 <= '0;
      stuck5 <= '0;
      repeat (30) @(posedge clk);
    end
    wr(aTo, 8'h00, 2'h0);
    stuck4 <= '1;
    stuck5 <= '1;
    quiet();
    wr(aTo, 8'hff, 2'h0);
    rd(aTo, 8'h07, 2'h0);
    quiet();
    wr(aEn, 8'h60, 2'h0);
    wr(aTo, 8'h01, 2'h0);
    quiet();
    stuck4 <= '0;
    wr(aEn, 8'h21, 2'h0);
    stuck4 <= '1;
    begin
      int c;
      waitPwr('0, 100 * T + 100, '1, c);
      inRange("fall4", c, 100 * T);
      chk("pwr5off", pwr5, 1'h1);
    end
    rd(aSt, 8'h0b, 2'h0);
    wr(aSt, 8'h03, 2'h0);
    rd(aSt, 8'h08, 2'h0);
    close_out();
  end
endmodule // test_split_port_link_watchdog
